// ---- hw/aof_filter.sv ----
/*
 * ADC oversampling/averaging post-filter with Avalon-MM register access,
 * sticky interrupt status, mask and one level interrupt.
 * Assumes samples and the bus master share clk; reset is asynchronous.
 */
//
// Contract
// RULE1: The filter works on results only while the enable bit 15 is one.
// RULE2: With the enable bit zero the data-ready flag is held clear.
// RULE3: Mode 11 averages, 00 oversamples, 10 and 01 are reserved.
// RULE4: Oversampling ratio codes 7..0 give 128,32,8,2,256,64,16,4 samples.
// RULE5: Oversampled results widen to 12.1, 12.2, 12.3 or 12.4 format.
// RULE6: Averaging ratio codes 7..0 give 256 down to 2 samples.
// RULE7: With interrupt enable set a ready result raises the ADC interrupt; the code also needs irq_mask bit 0 set.
// RULE8: The ready flag sets when a completed result is in the data register.
// RULE9: Reading the data register clears ready; software cannot write it.
// RULE10: Control bits 7 to 5 always read as zero.
// RULE11: Only results of the selected channel are accumulated.
// RULE12: Exactly the programmed count forms one output, then it restarts.
`default_nettype none
module aof_filter (
    // Clock, reset and clock enable.
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Conversion results from the ADC core.
    input wire logic sample_valid,
    input wire logic [4:0] sample_channel,
    input wire logic [11:0] sample_data,
    // Avalon-MM slave.
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    // Common ADC interrupt, level.
    output logic adc_irq
);

    typedef struct packed {
        logic [15:0] control;
        logic [15:0] result;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic [31:0] readdata;
        logic waitrequest;
        logic [1:0] response;
        logic irq;
    } aof_top_state_t;

    aof_top_state_t state_reg;
    aof_top_state_t state_next;
    aof_pkg::aof_cfg_t cfg;
    aof_pkg::aof_sample_t sample;
    logic [3:0] log2_count;
    logic [3:0] shift;
    logic acc_done;
    logic [15:0] acc_result;
    logic access;
    logic [15:0] wmask;
    logic [1:0] status_set;
    logic [1:0] status_clr;
    logic [1:0] status_new;

    // Byte enables spread to a 16-bit write mask.
    function automatic logic [15:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction

    // Configuration view of the control register.
    always_comb begin
        cfg.enable = state_reg.control[aof_pkg::FLD_ENABLE];
        cfg.mode = state_reg.control[aof_pkg::FLD_MODE_HI:
                                     aof_pkg::FLD_MODE_LO];
        cfg.ratio = state_reg.control[aof_pkg::FLD_RATIO_HI:
                                      aof_pkg::FLD_RATIO_LO];
        cfg.channel = state_reg.control[aof_pkg::FLD_CHAN_HI:
                                        aof_pkg::FLD_CHAN_LO];
        sample.valid = sample_valid;
        sample.channel = sample_channel;
        sample.data = sample_data;
    end

    aof_ratio_decode u_decode (
        .mode(cfg.mode),
        .ratio(cfg.ratio),
        .log2_count(log2_count),
        .shift(shift)
    );

    aof_accum u_accum (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .cfg(cfg),
        .log2_count(log2_count),
        .shift(shift),
        .sample(sample),
        .done(acc_done),
        .result(acc_result)
    );

    // Bus, result capture, flags and interrupt in one next-state block.
    // A request is answered one cycle after it is first seen, so
    // waitrequest is high in the request cycle and drops in the next.
    always_comb begin
        state_next = state_reg;
        access = (avs_read || avs_write) && state_reg.waitrequest;
        wmask = lane_mask(avs_byteenable) & aof_pkg::CONTROL_WMASK;
        status_set = 2'h0;
        status_clr = 2'h0;
        state_next.waitrequest = 1'b1;
        if (access) begin
            state_next.waitrequest = 1'b0;
            state_next.response = 2'h0;
            state_next.readdata = 32'h00000000;
            case (avs_address)
                aof_pkg::OFS_CONTROL: begin
                    // RULE10: unimplemented bits read zero
                    state_next.readdata = {16'h0000,
                                           state_reg.control & 16'hFF1F};
                    if (avs_write) begin
                        // RULE9: ready bit is not writable
                        // RULE3: mode field stored as written
                        state_next.control =
                            (state_reg.control & ~wmask) |
                            (avs_writedata[15:0] & wmask);
                    end
                end
                aof_pkg::OFS_RESULT: begin
                    state_next.readdata = {16'h0000, state_reg.result};
                    if (avs_read) begin
                        // RULE9: read clears ready
                        state_next.control[aof_pkg::FLD_READY] = 1'b0;
                    end
                end
                aof_pkg::OFS_IRQ_STATUS: begin
                    state_next.readdata = {30'h00000000,
                                           state_reg.irq_status};
                    if (avs_write && avs_byteenable[0]) begin
                        status_clr = avs_writedata[1:0];
                    end
                end
                aof_pkg::OFS_IRQ_MASK: begin
                    state_next.readdata = {30'h00000000,
                                           state_reg.irq_mask};
                    if (avs_write && avs_byteenable[0]) begin
                        state_next.irq_mask = avs_writedata[1:0];
                    end
                end
                default: begin
                    // Unmapped addresses answer with a slave error.
                    state_next.response = 2'h2;
                end
            endcase
        end
        // RULE8: completed result sets ready; wins over a clearing read.
        if (acc_done) begin
            state_next.result = acc_result;
            state_next.control[aof_pkg::FLD_READY] = 1'b1;
            // RULE7: event only when interrupt enable is set
            if (state_reg.control[aof_pkg::FLD_IRQ_EN]) begin
                status_set[aof_pkg::IRQ_BIT_READY] = 1'b1;
            end
            // An unread result being overwritten is flagged.
            if (state_reg.control[aof_pkg::FLD_READY]) begin
                status_set[aof_pkg::IRQ_BIT_OVERRUN] = 1'b1;
            end
        end
        // RULE2: disabled filter keeps ready clear
        if (!state_next.control[aof_pkg::FLD_ENABLE]) begin
            state_next.control[aof_pkg::FLD_READY] = 1'b0;
        end
        // Sticky status: a set in the same cycle beats the clear.
        status_new = (state_reg.irq_status & ~status_clr) | status_set;
        state_next.irq_status = status_new;
        // RULE7: unmasked status drives the common interrupt
        state_next.irq = |(status_new & state_next.irq_mask);
    end

    // State register; everything freezes while the clock enable is low.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg.control <= aof_pkg::CONTROL_RESET;
            state_reg.result <= aof_pkg::RESULT_RESET;
            state_reg.irq_status <= aof_pkg::IRQ_RESET;
            state_reg.irq_mask <= aof_pkg::IRQ_RESET;
            state_reg.readdata <= 32'h00000000;
            state_reg.waitrequest <= 1'b1;
            state_reg.response <= 2'h0;
            state_reg.irq <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flip-flops.
    assign avs_readdata = state_reg.readdata;
    assign avs_waitrequest = state_reg.waitrequest;
    assign avs_response = state_reg.response;
    assign adc_irq = state_reg.irq;

endmodule
`default_nettype wire

// ---- hw/aof_pkg.sv ----
/*
 * Package for the ADC oversampling/averaging filter: register map,
 * control field positions, reset values and the carrier structs.
 * Assumes a 32-bit Avalon-MM slave with word addresses in bytes.
 */
`default_nettype none
package aof_pkg;

    // Register byte offsets.
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_RESULT = 4'h4;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h8;
    localparam logic [3:0] OFS_IRQ_MASK = 4'hC;

    // Control register field positions.
    localparam int FLD_ENABLE = 15;
    localparam int FLD_MODE_HI = 14;
    localparam int FLD_MODE_LO = 13;
    localparam int FLD_RATIO_HI = 12;
    localparam int FLD_RATIO_LO = 10;
    localparam int FLD_IRQ_EN = 9;
    localparam int FLD_READY = 8;
    localparam int FLD_CHAN_HI = 4;
    localparam int FLD_CHAN_LO = 0;

    // Writable bits of the control register; bits 8 and 7..5 excluded.
    localparam logic [15:0] CONTROL_WMASK = 16'hFE1F;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] RESULT_RESET = 16'h0000;

    // Filter mode codes.
    localparam logic [1:0] MODE_OVERSAMPLE = 2'h0;
    localparam logic [1:0] MODE_AVERAGE = 2'h3;

    // Interrupt status bits.
    localparam int IRQ_BIT_READY = 0;
    localparam int IRQ_BIT_OVERRUN = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // One conversion result from the ADC core.
    typedef struct packed {
        logic valid;
        logic [4:0] channel;
        logic [11:0] data;
    } aof_sample_t;

    // Avalon-MM request from the master.
    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [31:0] writedata;
    } aof_bus_req_t;

    // Configuration handed to the accumulator.
    typedef struct packed {
        logic enable;
        logic [1:0] mode;
        logic [2:0] ratio;
        logic [4:0] channel;
    } aof_cfg_t;

endpackage
`default_nettype wire

// ---- hw/aof_ratio_decode.sv ----
/*
 * Ratio decoder: turns mode and ratio field into a log2 sample count
 * and a right shift for the accumulated sum.
 * Assumes purely combinational use by the filter top.
 */
`default_nettype none
module aof_ratio_decode (
    // Configuration.
    input wire logic [1:0] mode,
    input wire logic [2:0] ratio,
    // Decoded values.
    output logic [3:0] log2_count,
    output logic [3:0] shift
);

    // Count and shift; oversampling keeps half the extra bits.
    always_comb begin
        log2_count = 4'h1;
        shift = 4'h0;
        if (mode == aof_pkg::MODE_AVERAGE) begin
            // RULE6: averaging counts
            log2_count = {1'b0, ratio} + 4'h1;
            shift = log2_count;
        end else begin
            // RULE4: oversampling counts
            case (ratio)
                3'h7: log2_count = 4'h7;
                3'h6: log2_count = 4'h5;
                3'h5: log2_count = 4'h3;
                3'h4: log2_count = 4'h1;
                3'h3: log2_count = 4'h8;
                3'h2: log2_count = 4'h6;
                3'h1: log2_count = 4'h4;
                default: log2_count = 4'h2;
            endcase
            // RULE5: result grows by half the log2 ratio
            shift = {1'b0, log2_count[3:1]};
        end
    end

endmodule
`default_nettype wire

// ---- hw/aof_accum.sv ----
/*
 * Sample accumulator: sums the selected channel's results until the
 * programmed count is reached and emits one scaled result.
 * Assumes samples arrive synchronous to clk from the ADC core.
 */
`default_nettype none
module aof_accum (
    // Clock, reset, enable.
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Configuration and samples.
    input wire aof_pkg::aof_cfg_t cfg,
    input wire logic [3:0] log2_count,
    input wire logic [3:0] shift,
    input wire aof_pkg::aof_sample_t sample,
    // Completed result, one-cycle pulse.
    output logic done,
    output logic [15:0] result
);

    typedef struct packed {
        logic [19:0] sum;
        logic [8:0] count;
        logic done;
        logic [15:0] result;
    } aof_accum_state_t;

    aof_accum_state_t state_reg;
    aof_accum_state_t state_next;
    logic [19:0] sum_new;
    logic [8:0] target;

    // Accumulate and close a block when the count is reached.
    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        sum_new = state_reg.sum + {8'h00, sample.data};
        target = 9'h001 << log2_count;
        if (!cfg.enable) begin
            // RULE1: inactive filter drops its partial sum
            state_next.sum = 20'h00000;
            state_next.count = 9'h000;
        // RULE11: only the selected channel
        end else if (sample.valid && sample.channel == cfg.channel) begin
            // RULE12: exact count then restart
            if (state_reg.count + 9'h001 == target) begin
                state_next.result = 16'(sum_new >> shift);
                state_next.done = 1'b1;
                state_next.sum = 20'h00000;
                state_next.count = 9'h000;
            end else begin
                state_next.sum = sum_new;
                state_next.count = state_reg.count + 9'h001;
            end
        end
    end

    // State register; frozen while the clock enable is low.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    assign done = state_reg.done;
    assign result = state_reg.result;

endmodule
`default_nettype wire

// ---- dv/aof_adc_model.sv ----
/* ADC core model: sends bursts of results, each selected-channel result
   but the last followed by one result of the next channel, back to back.
   Assumes go is a one-cycle request, taken only while busy is low. */
`default_nettype none
module aof_adc_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Burst request.
    input wire logic go,
    input wire logic [8:0] cnt,
    input wire logic [4:0] chan,
    input wire logic [11:0] val,
    output logic busy,
    // Results towards the filter.
    output logic sample_valid,
    output logic [4:0] sample_channel,
    output logic [11:0] sample_data
);
    logic [8:0] left;
    logic odd;

    // Idle data lines toggle, so a stale value can never pass for a result.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            left <= 9'h000;
            odd <= 1'b0;
            sample_valid <= 1'b0;
            sample_channel <= 5'h00;
            sample_data <= 12'h000;
        end else if (go && !busy) begin
            left <= cnt;
            odd <= 1'b0;
        end else if (left != 9'h000) begin
            sample_valid <= 1'b1;
            sample_channel <= odd ? chan + 5'h01 : chan;
            sample_data <= odd ? ~val : val;
            if (!odd)
                left <= left - 9'h001;
            odd <= !odd;
        end else begin
            sample_valid <= 1'b0;
            sample_data <= ~sample_data;
        end
    end

    // Busy until the last result has left the lines.
    assign busy = (left != 9'h000) || sample_valid;
endmodule
`default_nettype wire

// ---- dv/aof_filter_sva.sv ----
/* Checker for the filter's bus, interrupt and sample ports.
   Assumes it is bound to aof_filter, one clock, rst asynchronous. */
`default_nettype none
module aof_filter_sva (
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Samples, bus and interrupt.
    input wire logic sample_valid,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response,
    input wire logic adc_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Answer edge of a bus cycle, and of a control register read.
    sequence s_answer;
        !avs_waitrequest && (avs_read || avs_write);
    endsequence
    sequence s_ctl_read;
        s_answer ##0 avs_read && avs_address == aof_pkg::OFS_CONTROL;
    endsequence

    // Bus handshake: one-cycle answer right after a request is seen.
    chk_wait_answer: assert property ((avs_read || avs_write) &&
        avs_waitrequest && ce |=> !avs_waitrequest)
        else $error("bus request not answered next cycle");
    chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer lasted more than one cycle");
    chk_no_unasked: assert property (!avs_waitrequest |->
        $past(avs_read || avs_write))
        else $error("bus answer without a request");
    chk_unmapped_err: assert property (s_answer ##0 avs_address[1:0] != 2'h0
        |-> avs_response == 2'h2 && (avs_write || avs_readdata == 32'h0))
        else $error("unmapped access not refused");

    // Control read-back fields.
    chk_gap_zero: assert property (
        s_ctl_read |-> avs_readdata[7:5] == 3'h0)
        else $error("control bits 7 to 5 read nonzero");
    chk_ready_idle: assert property (
        s_ctl_read |-> avs_readdata[15] || !avs_readdata[8])
        else $error("ready set while filter disabled");

    // Interrupt edges need a sample or a register access as their cause.
    // A register write changes the level in the same edge that answers it.
    chk_irq_cause: assert property ($rose(adc_irq) |->
        $past(sample_valid, 2) || $past(sample_valid, 3) ||
        !avs_waitrequest)
        else $error("interrupt rose without cause");
    chk_irq_clear: assert property ($fell(adc_irq) |->
        !avs_waitrequest)
        else $error("interrupt fell without register access");
endmodule

bind aof_filter aof_filter_sva u_sva (
    .clk(clk), .rst(rst), .ce(ce), .sample_valid(sample_valid),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .adc_irq(adc_irq)
);
`default_nettype wire

// ---- dv/aof_filter_bench.sv ----
/* Self-checking bench: registers, gating, masking and every ratio code.
   Assumes the ADC core model and the bound checker; ce is driven here. */
`default_nettype none
module aof_filter_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic go = 1'b0;
    logic [8:0] cnt = 9'h000;
    logic [11:0] val = 12'h000;
    logic busy, sample_valid, adc_irq, avs_waitrequest;
    logic [4:0] sample_channel;
    logic [11:0] sample_data;
    logic [3:0] avs_address = 4'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [1:0] avs_response, r;
    int n_errors = 0;
    int comparisons = 0;
    int ovs_n[8] = '{4, 16, 64, 256, 2, 8, 32, 128};

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    aof_adc_model u_adc (.clk(clk), .rst(rst), .go(go), .cnt(cnt),
        .chan(5'h05), .val(val), .busy(busy), .sample_valid(sample_valid),
        .sample_channel(sample_channel), .sample_data(sample_data));
    aof_filter u_dut (.clk(clk), .rst(rst), .ce(ce),
        .sample_valid(sample_valid), .sample_channel(sample_channel),
        .sample_data(sample_data), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .adc_irq(adc_irq));

    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask

    // A lost handshake ends the run rather than hanging it.
    task automatic give_up(input string nm);
        check(nm, 32'h1, 32'h0);
        print_verdict();
    endtask

    // One bus cycle; waitrequest and the answer are taken at a rising edge,
    // and the request is released only after that edge.
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [15:0] d, input logic [3:0] be);
        int i;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= be;
        avs_read <= !w;
        avs_write <= w;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        if (i == 20)
            give_up("bus answer");
        q = avs_readdata;
        r = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e,
                      input string nm);
        bus(1'b0, a, 16'h0000, 4'hF);
        check(nm, e, q);
    endtask

    // Ready appears two cycles after the last sample; four is ample.
    task automatic settle(input logic e, input string nm);
        repeat (4) @(negedge clk);
        check(nm, {31'h0, e}, {31'h0, adc_irq});
    endtask

    task automatic run(input int n, input logic [11:0] v);
        int i;
        @(posedge clk);
        go <= 1'b1;
        cnt <= n[8:0];
        val <= v;
        @(posedge clk);
        go <= 1'b0;
        for (i = 0; i < 700; i++) begin
            @(negedge clk);
            if (busy === 1'b0)
                break;
        end
        if (i == 700)
            give_up("samples sent");
    endtask

    task automatic t_regs;
        rd(aof_pkg::OFS_CONTROL, 32'h0, "control reset");
        rd(aof_pkg::OFS_RESULT, 32'h0, "result reset");
        rd(aof_pkg::OFS_IRQ_STATUS, 32'h0, "status reset");
        rd(aof_pkg::OFS_IRQ_MASK, 32'h0, "mask reset");
        wr(aof_pkg::OFS_CONTROL, 16'hFFFF);
        rd(aof_pkg::OFS_CONTROL, 32'hFE1F, "control bits");
        bus(1'b1, aof_pkg::OFS_CONTROL, 16'h0000, 4'h1);
        rd(aof_pkg::OFS_CONTROL, 32'hFE00, "low lane write");
        wr(aof_pkg::OFS_CONTROL, 16'h0000);
        bus(1'b0, 4'h2, 16'h0000, 4'hF);
        check("unmapped read response", 32'h2, {30'h0, r});
        check("unmapped read data", 32'h0, q);
        bus(1'b1, 4'h6, 16'hFFFF, 4'hF);
        check("unmapped write response", 32'h2, {30'h0, r});
        rd(aof_pkg::OFS_CONTROL, 32'h0, "unmapped write ignored");
        wr(aof_pkg::OFS_IRQ_MASK, 16'h0001);
        $display("test registers done");
    endtask

    task automatic t_gate;
        wr(aof_pkg::OFS_CONTROL, 16'h6205);
        run(2, 12'h123);
        settle(1'b0, "irq while disabled");
        rd(aof_pkg::OFS_CONTROL, 32'h6205, "ready while disabled");
        wr(aof_pkg::OFS_CONTROL, 16'hE205);
        run(1, 12'h123);
        settle(1'b0, "disabled samples dropped");
        run(1, 12'h123);
        settle(1'b1, "irq after enable");
        wr(aof_pkg::OFS_IRQ_MASK, 16'h0000);
        settle(1'b0, "irq masked");
        wr(aof_pkg::OFS_IRQ_MASK, 16'h0001);
        settle(1'b1, "irq unmasked");
        wr(aof_pkg::OFS_CONTROL, 16'h6205);
        rd(aof_pkg::OFS_CONTROL, 32'h6205, "ready off disabled");
        wr(aof_pkg::OFS_IRQ_STATUS, 16'h0001);
        wr(aof_pkg::OFS_CONTROL, 16'hE005);
        run(2, 12'h123);
        settle(1'b0, "irq enable clear");
        rd(aof_pkg::OFS_CONTROL, 32'hE105, "ready without irq");
        rd(aof_pkg::OFS_IRQ_STATUS, 32'h0, "status without irq");
        wr(aof_pkg::OFS_CONTROL, 16'h0000);
        $display("test gating done");
    endtask

    // Frozen cycles must lose samples; a second unread result is an overrun.
    task automatic t_freeze;
        wr(aof_pkg::OFS_CONTROL, 16'hE205);
        run(1, 12'h0F0);
        @(posedge clk);
        ce <= 1'b0;
        run(2, 12'h0F0);
        @(posedge clk);
        ce <= 1'b1;
        settle(1'b0, "irq after frozen samples");
        run(1, 12'h0F0);
        settle(1'b1, "irq after freeze");
        run(2, 12'h0F0);
        rd(aof_pkg::OFS_IRQ_STATUS, 32'h3, "overrun status");
        rd(aof_pkg::OFS_RESULT, 32'h0F0, "result after freeze");
        wr(aof_pkg::OFS_IRQ_STATUS, 16'h0003);
        settle(1'b0, "irq after status clear");
        wr(aof_pkg::OFS_CONTROL, 16'h0000);
        $display("test freeze done");
    endtask

    task automatic t_ratio(input logic [1:0] md, input logic [2:0] c);
        int n, sh;
        logic [11:0] v;
        logic [15:0] ctl, e;
        n = (md == aof_pkg::MODE_AVERAGE) ? (2 << c) : ovs_n[c];
        sh = (md == aof_pkg::MODE_AVERAGE) ? $clog2(n) : $clog2(n) / 2;
        v = {9'h1E0, c};
        e = 16'((n * v) >> sh);
        ctl = {1'b1, md, c, 1'b1, 4'h0, 5'h05};
        wr(aof_pkg::OFS_CONTROL, ctl);
        run(n - 1, v);
        settle(1'b0, "irq one short");
        run(1, v);
        settle(1'b1, "irq at result");
        rd(aof_pkg::OFS_CONTROL, {16'h0, ctl | 16'h0100}, "ready");
        rd(aof_pkg::OFS_RESULT, {16'h0, e}, "result");
        rd(aof_pkg::OFS_CONTROL, {16'h0, ctl}, "ready read");
        wr(aof_pkg::OFS_IRQ_STATUS, 16'h0001);
        settle(1'b0, "irq cleared");
        wr(aof_pkg::OFS_CONTROL, 16'h0000);
        $display("test ratio mode %h code %h done", md, c);
    endtask

    // Main sequence: reset, registers, gating, freeze, then all ratio codes.
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_gate();
        t_freeze();
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 8; c++) begin
                t_ratio(m ? aof_pkg::MODE_AVERAGE : aof_pkg::MODE_OVERSAMPLE,
                        3'(c));
            end
        end
        print_verdict();
    end
endmodule
`default_nettype wire
